/* File: dv/pin_partner.sv */
`timescale 1ns/1ps

// ********
// far-side pins: trigger lines, count input, shared pin resolution
// ********
module pin_partner (
	input  wire logic       ref_clk,
	input  wire logic [2:0] pin_out,
	input  wire logic [2:0] pin_oe_n,
	output logic      [2:0] trig,
	output logic      [2:0] pin_in
);
	logic [2:0] drv = 3'h7;

	initial trig = 3'h7;

	// shared pin: device level wins while it drives, else our drv level
	always_comb begin
		for (int i = 0; i < 3; i++)
			pin_in[i] = pin_oe_n[i] ? drv[i] : pin_out[i];
	end

	// low held four edges so the two-flop synchroniser cannot miss it
	task automatic fall_trig(input int ch);
		@(posedge ref_clk) trig[ch] <= 1'b0;
		repeat (4) @(posedge ref_clk);
		trig[ch] <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask

	// n slow falls on the count input
	task automatic pin_falls(input int ch, input int n);
		repeat (n) begin
			@(posedge ref_clk) drv[ch] <= 1'b0;
			repeat (3) @(posedge ref_clk);
			drv[ch] <= 1'b1;
			repeat (3) @(posedge ref_clk);
		end
	endtask
endmodule // pin_partner

/* File: dv/tb_capture_pwm_timer.sv */
`timescale 1ns/1ps

module tb_capture_pwm_timer import timer_pkg::*;;
	// ********
	// signals
	// ********
	typedef struct {int k; int ch; logic [15:0] exp; logic [15:0] got;} note_t;
	logic             ref_clk = 1'b0;
	logic             rst = 1'b1;
	logic             ce = 1'b1;
	logic [2:0][1:0]  mode_sel = '0;
	logic [2:0]       run_enable = '0, count_source_select = '0, ext_trigger_enable = '0, pwm_enable_bit = '0;
	logic [2:0]       channel_irq_enable = '0, toggle_output_enable = '0, output_polarity_select = '0;
	logic [2:0]       wr_count = '0, wr_capture = '0, wr_free_cycle = '0;
	logic [1:0]       wr_byte_en = 2'h3;
	logic [15:0]      wr_data = '0;
	logic [5:0]       flag_clear = '0;
	logic [2:0]       capture_trigger_pin, channel_pin_in, channel_pin_out, channel_pin_oe_n, irq;
	logic [2:0][15:0] count_value, capture_value, free_cycle_value;
	logic [5:0]       shared_timer_flags;
	note_t            q[$];
	int               fails = 0;
	int               n_checks = 0;

	capture_pwm_timer dut (
		.ref_clk                (ref_clk),
		.rst                    (rst),
		.ce                     (ce),
		.mode_sel               (mode_sel),
		.run_enable             (run_enable),
		.count_source_select    (count_source_select),
		.ext_trigger_enable     (ext_trigger_enable),
		.pwm_enable_bit         (pwm_enable_bit),
		.channel_irq_enable     (channel_irq_enable),
		.toggle_output_enable   (toggle_output_enable),
		.output_polarity_select (output_polarity_select),
		.wr_count               (wr_count),
		.wr_capture             (wr_capture),
		.wr_free_cycle          (wr_free_cycle),
		.wr_byte_en             (wr_byte_en),
		.wr_data                (wr_data),
		.flag_clear             (flag_clear),
		.capture_trigger_pin    (capture_trigger_pin),
		.channel_pin_in         (channel_pin_in),
		.channel_pin_out        (channel_pin_out),
		.channel_pin_oe_n       (channel_pin_oe_n),
		.count_value            (count_value),
		.capture_value          (capture_value),
		.free_cycle_value       (free_cycle_value),
		.shared_timer_flags     (shared_timer_flags),
		.irq                    (irq)
	);
	pin_partner u_pins (.ref_clk(ref_clk), .pin_out(channel_pin_out), .pin_oe_n(channel_pin_oe_n),
		.trig(capture_trigger_pin), .pin_in(channel_pin_in));

	initial forever #50 ref_clk = ~ref_clk;

	// ********
	// tasks
	// ********
	task automatic tally_and_finish();
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask

	task automatic note(input int k, input int ch, input logic [15:0] exp, input logic [15:0] got = 16'h0);
		q.push_back('{k, ch, exp, got});
	endtask

	// strobe held one edge, then a spare edge so strobes never collide
	task automatic wr(input int sel, input int ch, input logic [15:0] d, input logic [1:0] be = 2'h3);
		@(posedge ref_clk);
		wr_data <= d;
		wr_byte_en <= be;
		{wr_free_cycle[ch], wr_capture[ch], wr_count[ch]} <= 3'(1 << sel);
		@(posedge ref_clk);
		{wr_free_cycle[ch], wr_capture[ch], wr_count[ch]} <= 3'h0;
	endtask

	// bits: run, source, trigger, pwm, irq enable, toggle, polarity
	task automatic cfg(input int ch, input logic [1:0] m, input logic [6:0] b);
		@(posedge ref_clk);
		mode_sel[ch] <= m;
		{run_enable[ch], count_source_select[ch], ext_trigger_enable[ch], pwm_enable_bit[ch],
			channel_irq_enable[ch], toggle_output_enable[ch], output_polarity_select[ch]} <= b;
	endtask

	task automatic clr(input int b);
		@(posedge ref_clk) flag_clear[b] <= 1'b1;
		@(posedge ref_clk) flag_clear[b] <= 1'b0;
	endtask

	// watcher: settled outputs compared against the oldest notes
	always @(negedge ref_clk) begin : watch
		note_t e;
		while (q.size() > 0) begin
			e = q.pop_front();
			case (e.k)
				0: cmp16(count_value[e.ch], e.exp, "count");
				1: cmp16(capture_value[e.ch], e.exp, "capture");
				2: cmp1(shared_timer_flags[2*e.ch+1], e.exp[0], "overflow flag");
				3: cmp1(shared_timer_flags[2*e.ch], e.exp[0], "event flag");
				4: cmp1(irq[e.ch], e.exp[0], "irq");
				5: cmp1(channel_pin_out[e.ch], e.exp[0], "pin");
				6: cmp1(channel_pin_oe_n[e.ch], e.exp[0], "pin enable");
				default: cmp16(e.got, e.exp, "high count");
			endcase
		end
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		$display("Error %0t: run did not complete", $time);
		tally_and_finish();
	end

	// ********
	// stimulus
	// ********
	initial begin : main
		int ch, hi, fl, ir;
		logic [15:0] v;
		static logic [15:0] duty [6] = '{16'h2, 16'h2, 16'h0, 16'h0, 16'h3, 16'h0};
		static logic [15:0] free [6] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h0, 16'h0};
		static logic [5:0]  pols = 6'h1a;
		static int          exp_hi [6] = '{20, 10, 0, 0, 30, 30};
		void'($urandom(2867));
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		for (ch = 0; ch < 3; ch++) begin
			note(0, ch, 16'h0);
			note(6, ch, 16'h1);
		end
		// capture on every channel, overwrite, then trigger disabled
		for (ch = 0; ch < 3; ch++) begin
			v = 16'($urandom());
			cfg(ch, MODE_CAPTURE, 7'h14);
			wr(0, ch, v);
			u_pins.fall_trig(ch);
			note(1, ch, v);
			note(3, ch, 16'h1);
			note(4, ch, 16'h1);
			note(0, ch, v);
			wr(0, ch, ~v);
			u_pins.fall_trig(ch);
			note(1, ch, ~v);
			cfg(ch, MODE_CAPTURE, 7'h04);
			wr(0, ch, v);
			u_pins.fall_trig(ch);
			note(1, ch, ~v);
			clr(2 * ch);
			note(4, ch, 16'h0);
		end
		// one tick from ffff rolls over; flag stays until cleared
		ch = $urandom_range(2, 0);
		wr(0, ch, 16'hffff);
		cfg(ch, MODE_CAPTURE, 7'h44);
		cfg(ch, MODE_CAPTURE, 7'h04);
		note(0, ch, 16'h0);
		note(2, ch, 16'h1);
		repeat (3) @(posedge ref_clk);
		note(2, ch, 16'h1);
		clr(2 * ch + 1);
		note(2, ch, 16'h0);
		wr(0, ch, 16'hab12, 2'h1);
		note(0, ch, 16'h0012);
		// clock enable low freezes the counter even while run is set
		@(posedge ref_clk) ce <= 1'b0;
		cfg(ch, MODE_CAPTURE, 7'h44);
		repeat (5) @(posedge ref_clk);
		note(0, ch, 16'h0012);
		@(posedge ref_clk) ce <= 1'b1;
		cfg(ch, MODE_CAPTURE, 7'h04);
		note(0, ch, 16'h0013);
		// capture while counting: the pulse lands two ticks after the pin fall
		cfg(ch, MODE_CAPTURE, 7'h54);
		u_pins.fall_trig(ch);
		cfg(ch, MODE_CAPTURE, 7'h04);
		note(1, ch, 16'h0016);
		note(0, ch, 16'h001d);
		clr(2 * ch);
		// counting falls on the shared pin
		cfg(ch, MODE_CAPTURE, 7'h60);
		wr(0, ch, 16'h0);
		u_pins.pin_falls(ch, 5);
		repeat (4) @(posedge ref_clk);
		note(0, ch, 16'h5);
		// pwm table: 30 cycles is a whole number of 3-cycle periods
		for (int i = 0; i < 6; i++) begin
			cfg(ch, MODE_PWM, 7'h0c);
			wr(1, ch, duty[i]);
			wr(2, ch, free[i]);
			wr(0, ch, 16'h0); // pwm entry keeps the old count, so restart it
			cfg(ch, MODE_PWM, 7'h4c | 7'(pols[i]));
			repeat (10) @(posedge ref_clk);
			hi = 0;
			fl = 0;
			ir = 0;
			repeat (30) begin
				@(negedge ref_clk);
				hi += int'(channel_pin_out[ch] === 1'b1);
				fl += int'(shared_timer_flags[2*ch+1] === 1'b1);
				ir += int'(irq[ch] === 1'b1);
			end
			@(posedge ref_clk);
			note(7, ch, 16'(exp_hi[i]), 16'(hi));
			note(6, ch, 16'h0);
			if (i < 2) begin
				note(7, ch, 16'h14, 16'(fl));
				note(7, ch, 16'h14, 16'(ir));
			end
		end
		// toggle output: clock source kept, starts high, flips on overflow
		cfg(ch, MODE_AUTO_RELOAD, 7'h00);
		wr(1, ch, 16'hfff0);
		wr(0, ch, 16'hfffe);
		cfg(ch, MODE_AUTO_RELOAD, 7'h02);
		repeat (3) @(posedge ref_clk);
		note(5, ch, 16'h1);
		note(6, ch, 16'h0);
		cfg(ch, MODE_AUTO_RELOAD, 7'h42);
		repeat (10) @(posedge ref_clk);
		note(5, ch, 16'h0);
		repeat (16) @(posedge ref_clk);
		note(5, ch, 16'h1);
		@(posedge ref_clk);
		@(posedge ref_clk);
		tally_and_finish();
	end
endmodule // tb_capture_pwm_timer

/* File: hw/capture_pwm_timer.sv */
`timescale 1ns/1ps
`include "timer_defs.svh"

module capture_pwm_timer
	import timer_pkg::*;
(
	input  wire logic            ref_clk,
	input  wire logic            rst,
	input  wire logic            ce,
	input  wire logic [2:0][1:0] mode_sel,
	input  wire logic [2:0]      run_enable,
	input  wire logic [2:0]      count_source_select,
	input  wire logic [2:0]      ext_trigger_enable,
	input  wire logic [2:0]      pwm_enable_bit,
	input  wire logic [2:0]      channel_irq_enable,
	input  wire logic [2:0]      toggle_output_enable,
	input  wire logic [2:0]      output_polarity_select,
	input  wire logic [2:0]      wr_count,
	input  wire logic [2:0]      wr_capture,
	input  wire logic [2:0]      wr_free_cycle,
	input  wire logic [1:0]      wr_byte_en,
	input  wire logic [15:0]     wr_data,
	input  wire logic [5:0]      flag_clear,
	input  wire logic [2:0]      capture_trigger_pin,
	input  wire logic [2:0]      channel_pin_in,
	output logic      [2:0]      channel_pin_out,
	output logic      [2:0]      channel_pin_oe_n,
	output logic      [2:0][15:0] count_value,
	output logic      [2:0][15:0] capture_value,
	output logic      [2:0][15:0] free_cycle_value,
	output logic      [5:0]      shared_timer_flags,
	output logic      [2:0]      irq
);

	// ****************************************
	// state
	// ****************************************
	logic [2:0][15:0] count_r;
	logic [2:0][15:0] count_nxt;
	logic [2:0][15:0] capture_r;
	logic [2:0][15:0] capture_nxt;
	logic [2:0][15:0] free_r;
	logic [2:0][15:0] free_nxt;
	logic [2:0]       ovf_r;
	logic [2:0]       ovf_nxt;
	logic [2:0]       ext_r;
	logic [2:0]       ext_nxt;
	logic [2:0]       pwm_hi_r;
	logic [2:0]       pwm_hi_nxt;
	logic [2:0]       tog_r;
	logic [2:0]       tog_nxt;
	logic [2:0]       ten_prev_r;
	logic [2:0]       ten_prev_nxt;
	logic [2:0]       pin_r;
	logic [2:0]       pin_nxt;
	logic [2:0]       oe_n_r;
	logic [2:0]       oe_n_nxt;
	logic [2:0]       irq_r;
	logic [2:0]       irq_nxt;
	logic [5:0]       falls;
	logic [2:0]       trig_fall;
	logic [2:0]       cnt_fall;
	logic [2:0]       tick;

	// byte-lane merge for the three writable 16-bit registers
	function automatic logic [15:0] merge_bytes(
		input logic [15:0] old_v,
		input logic [15:0] new_v,
		input logic [1:0]  be
	);
		return {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

	// ****************************************
	// pin sampling
	// ****************************************
	pin_fall_detect u_fall (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.ce         (ce),
		.pin_in     ({channel_pin_in, capture_trigger_pin}),
		.fall_pulse (falls)
	);

	// low three are trigger pins, high three the count pins
	assign trig_fall = falls[2:0];
	assign cnt_fall  = falls[5:3];

	// count source: clock tick or pin fall
	assign tick = run_enable & (count_source_select & cnt_fall | ~count_source_select);

	// ****************************************
	// channel next-state
	// ****************************************
	always_comb begin
		mode_t mode;
		logic  ovf_evt;
		logic  drive;
		mode = MODE_AUTO_RELOAD;
		ovf_evt = 1'b0;
		drive = 1'b0;
		for (int i = 0; i < `NUM_CH; i++) begin
			mode = mode_t'(mode_sel[i]);
			ovf_evt = 1'b0;
			count_nxt[i] = count_r[i];
			capture_nxt[i] = capture_r[i];
			free_nxt[i] = free_r[i];
			pwm_hi_nxt[i] = pwm_hi_r[i];
			// software clears first so a same-cycle hardware set wins
			ovf_nxt[i] = ovf_r[i] & ~flag_clear[`FLAGS_PER_CH*i+`FLAG_OVF_POS];
			ext_nxt[i] = ext_r[i] & ~flag_clear[`FLAGS_PER_CH*i+`FLAG_EXT_POS];
			case (mode)
				MODE_CAPTURE: begin
					// counter never stopped by a capture
					if (tick[i]) begin
						count_nxt[i] = count_r[i] + `COUNT_ONE;
						if (count_r[i] == `COUNT_MAX) begin
							ovf_nxt[i] = 1'b1;
							ovf_evt = 1'b1;
						end
					end
					// no overwrite guard: every edge replaces the value
					if (ext_trigger_enable[i] && trig_fall[i]) begin
						capture_nxt[i] = count_r[i];
						ext_nxt[i] = 1'b1;
					end
				end
				MODE_PWM: begin
					// capture register doubles as duty length
					if (tick[i]) begin
						if (pwm_hi_r[i] && count_r[i] == capture_r[i] - `COUNT_ONE) begin
							pwm_hi_nxt[i] = 1'b0;
							ovf_nxt[i] = 1'b0;
							count_nxt[i] = `COUNT_RST;
						end else if (!pwm_hi_r[i] && count_r[i] == free_r[i] - `COUNT_ONE) begin
							pwm_hi_nxt[i] = 1'b1;
							ovf_nxt[i] = 1'b1;
							ovf_evt = 1'b1;
							count_nxt[i] = `COUNT_RST;
						end else begin
							count_nxt[i] = count_r[i] + `COUNT_ONE;
						end
					end
				end
				default: begin
					// auto-reload: reload from capture register on overflow or trigger
					if (tick[i]) begin
						if (count_r[i] == `COUNT_MAX) begin
							count_nxt[i] = capture_r[i];
							ovf_nxt[i] = 1'b1;
							ovf_evt = 1'b1;
						end else begin
							count_nxt[i] = count_r[i] + `COUNT_ONE;
						end
					end
					if (ext_trigger_enable[i] && trig_fall[i]) begin
						count_nxt[i] = capture_r[i];
						ext_nxt[i] = 1'b1;
					end
				end
			endcase
			// pwm phase restarts high whenever pwm mode is left
			if (mode != MODE_PWM) begin
				pwm_hi_nxt[i] = 1'b1;
			end
			// software writes take priority over counting
			if (wr_count[i]) begin
				count_nxt[i] = merge_bytes(count_r[i], wr_data, wr_byte_en);
			end
			if (wr_capture[i]) begin
				capture_nxt[i] = merge_bytes(capture_r[i], wr_data, wr_byte_en);
			end
			if (wr_free_cycle[i]) begin
				free_nxt[i] = merge_bytes(free_r[i], wr_data, wr_byte_en);
			end
			// toggle output: high on enable, inverted per overflow
			ten_prev_nxt[i] = toggle_output_enable[i];
			tog_nxt[i] = tog_r[i];
			if (toggle_output_enable[i] && !ten_prev_r[i]) begin
				tog_nxt[i] = 1'b1;
			end else if (ovf_evt) begin
				tog_nxt[i] = ~tog_r[i];
			end
			// shared pin: pwm first, then toggle, else input
			if (pwm_enable_bit[i] && free_r[i] == `FREE_RST) begin
				drive = 1'b1;
			end else if (pwm_enable_bit[i] && capture_r[i] == `CAPTURE_RST) begin
				drive = 1'b0;
			end else if (pwm_enable_bit[i]) begin
				drive = pwm_hi_r[i] ^ output_polarity_select[i];
			end else begin
				drive = tog_r[i] ^ output_polarity_select[i];
			end
			pin_nxt[i] = drive;
			oe_n_nxt[i] = ~(pwm_enable_bit[i] | toggle_output_enable[i]);
			// one request line for both flags
			irq_nxt[i] = channel_irq_enable[i] & (ovf_nxt[i] | ext_nxt[i]);
		end
	end

	// ****************************************
	// registers, frozen while ce is low
	// ****************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_r <= {3{`COUNT_RST}};
			capture_r <= {3{`CAPTURE_RST}};
			free_r <= {3{`FREE_RST}};
			ovf_r <= 3'h0;
			ext_r <= 3'h0;
			pwm_hi_r <= 3'h7;
			tog_r <= 3'h7;
			ten_prev_r <= 3'h0;
			pin_r <= 3'h7;
			oe_n_r <= 3'h7;
			irq_r <= 3'h0;
		end else if (ce) begin
			count_r <= count_nxt;
			capture_r <= capture_nxt;
			free_r <= free_nxt;
			ovf_r <= ovf_nxt;
			ext_r <= ext_nxt;
			pwm_hi_r <= pwm_hi_nxt;
			tog_r <= tog_nxt;
			ten_prev_r <= ten_prev_nxt;
			pin_r <= pin_nxt;
			oe_n_r <= oe_n_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign count_value = count_r;
	assign capture_value = capture_r;
	assign free_cycle_value = free_r;
	assign channel_pin_out = pin_r;
	assign channel_pin_oe_n = oe_n_r;
	assign irq = irq_r;
	assign shared_timer_flags = {ovf_r[2], ext_r[2], ovf_r[1], ext_r[1], ovf_r[0], ext_r[0]};

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	for (genvar g = 0; g < `NUM_CH; g++) begin : g_chk
		chk_count_up: assert property (
			ce && mode_sel[g] == MODE_CAPTURE && tick[g] && !wr_count[g]
			|=> count_r[g] == $past(count_r[g]) + `COUNT_ONE)
			else $error("count did not advance");
		chk_ovf_flag: assert property (
			ce && mode_sel[g] == MODE_CAPTURE && tick[g] && count_r[g] == `COUNT_MAX
			|=> ovf_r[g] && count_r[g] == `COUNT_RST || $past(wr_count[g]))
			else $error("rollover missed overflow flag");
		chk_capture_copy: assert property (
			ce && mode_sel[g] == MODE_CAPTURE && ext_trigger_enable[g] && trig_fall[g] && !wr_capture[g]
			|=> capture_r[g] == $past(count_r[g]))
			else $error("capture value wrong");
		chk_ext_flag: assert property (
			ce && mode_sel[g] == MODE_CAPTURE && ext_trigger_enable[g] && trig_fall[g]
			|=> ext_r[g])
			else $error("external flag not set");
		chk_irq_follow: assert property (
			ce |=> irq_r[g] == ($past(channel_irq_enable[g]) && (ovf_r[g] || ext_r[g])))
			else $error("interrupt request mismatch");
		chk_duty_zero_low: assert property (
			ce && pwm_enable_bit[g] && capture_r[g] == `CAPTURE_RST && free_r[g] != `FREE_RST
			|=> !channel_pin_out[g] && !channel_pin_oe_n[g])
			else $error("duty zero did not force low");
		chk_free_zero_high: assert property (
			ce && pwm_enable_bit[g] && free_r[g] == `FREE_RST
			|=> channel_pin_out[g])
			else $error("free zero did not force high");
		chk_toggle_start: assert property (
			ce && toggle_output_enable[g] && !ten_prev_r[g]
			|=> tog_r[g])
			else $error("toggle output did not start high");
		chk_sw_clear_only: assert property (
			ce && mode_sel[g] != MODE_PWM && ovf_r[g] && !flag_clear[`FLAGS_PER_CH*g+`FLAG_OVF_POS]
			|=> ovf_r[g])
			else $error("overflow flag lost without clear");
	end

endmodule // capture_pwm_timer

/* File: hw/pin_fall_detect.sv */
`timescale 1ns/1ps
`include "timer_defs.svh"

// ****************************************
// two-stage synchroniser and falling-edge pulse for six pins
// ****************************************
module pin_fall_detect (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [5:0] pin_in,
	output logic      [5:0] fall_pulse
);

	logic [5:0] meta_r;
	logic [5:0] sync_r;
	logic [5:0] prev_r;
	logic [5:0] meta_nxt;
	logic [5:0] sync_nxt;
	logic [5:0] prev_nxt;

	// stages only advance with the clock enable
	always_comb begin
		meta_nxt = ce ? pin_in : meta_r;
		sync_nxt = ce ? meta_r : sync_r;
		prev_nxt = ce ? sync_r : prev_r;
	end

	// pins idle high, so reset to ones to avoid a false edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meta_r <= 6'h3f;
			sync_r <= 6'h3f;
			prev_r <= 6'h3f;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
		end
	end

	// one cycle of high per detected 1-to-0 step
	assign fall_pulse = prev_r & ~sync_r & {6{ce}};

endmodule // pin_fall_detect

/* File: pkg/timer_defs.svh */
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ****************************************
// sizes
// ****************************************
`define NUM_CH        3
`define COUNT_W       16
`define MODE_W        2

// ****************************************
// shared flag layout: two bits per channel
// ****************************************
`define FLAGS_PER_CH  2
`define FLAG_EXT_POS  0
`define FLAG_OVF_POS  1

// ****************************************
// reset values and limits
// ****************************************
`define COUNT_RST     16'h0000
`define CAPTURE_RST   16'h0000
`define FREE_RST      16'h0000
`define COUNT_MAX     16'hffff
`define COUNT_ONE     16'h0001

`endif

/* File: pkg/timer_pkg.sv */
package timer_pkg;

	// channel operating modes, auto-reload first so an all-zero mode_sel selects it
	typedef enum logic [1:0] {
		MODE_AUTO_RELOAD,
		MODE_CAPTURE,
		MODE_PWM
	} mode_t;

endpackage
